// ===== hdl/odr_pin_if.sv
// Carrier between the pin sampler and the register core
`timescale 1ns/1ps
`default_nettype none

interface odr_pin_if #(
  parameter int W = 14
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;

  modport sampler (
    input raw,
    output synced
  );

  modport user (
    output raw,
    input synced
  );
endinterface : odr_pin_if

`default_nettype wire

// ===== hdl/odr_pin_sync.sv
// Two-stage synchroniser for the asynchronous pin bundle
`timescale 1ns/1ps
`default_nettype none

module odr_pin_sync #(
  parameter int W = 14,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Pins in, settled copy out
  odr_pin_if.sampler pins
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] settled_r;
  logic [W-1:0] settled_nxt;

  // First stage feeds only the second stage
  always_comb
  begin
    meta_nxt = pins.raw;
    settled_nxt = meta_r;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      meta_r <= RESET_VAL;
      settled_r <= RESET_VAL;
    end
    else
    begin
      meta_r <= meta_nxt;
      settled_r <= settled_nxt;
    end
  end

  assign pins.synced = settled_r;

endmodule : odr_pin_sync

`default_nettype wire

// ===== hdl/odr_pkg.sv
// Shared constants for the eight-bit edge-sampled register with gated outputs
package odr_pkg;

  // ------------------------------------------------------------
  // Word and pin bundle layout
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int PIN_W = 14;
  localparam int SYNC_STAGES = 2;

  // Bit positions inside the synchronised pin bundle
  localparam int POS_DIN_LO = 0;
  localparam int POS_DRIVE_A = 8;
  localparam int POS_DRIVE_B = 9;
  localparam int POS_DRIVE_C = 10;
  localparam int POS_LOAD_HOLD = 11;
  localparam int POS_ZERO_ALL = 12;
  localparam int POS_SAMPLE_CLK = 13;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic [DATA_W-1:0] WORD_RESET = 8'h00;
  localparam logic [DATA_W-1:0] OE_RESET = 8'h00;
  // Clock bit starts high so a pin already high at release is no edge;
  // enables start high so the outputs stay released
  localparam logic [PIN_W-1:0] PIN_RESET = 14'h3700;
  localparam logic SAMPLE_CLK_RESET = 1'b1;

endpackage : odr_pkg

// ===== hdl/odr_register.sv
// Eight-bit edge-sampled register with load hold, clear and three-way output gate
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Eight separate storage bits hold the word, one per data input.
// - Each bit takes its data input on a sample clock rising edge when loading.
// - One sample clock and one combined enable govern all eight bits alike.
// - Outputs drive the word only while all three active-low enables are low.
// - Any enable high releases all eight outputs to float.
// - Enable changes never touch the stored word, only drive or float.
// - Clear low forces the word to zero over clock, hold and data.
// - New data enters storage only while clear is high.
// - Clear high and hold low: a rising edge loads the data inputs.
// - Hold high with clear high keeps the word whatever clock and data do.
// - Inverting build drives the complement; non-inverting drives the word.
module odr_register
  import odr_pkg::*;
#(
  parameter bit INVERT_OUT = 1'b0,
  parameter int W = odr_pkg::DATA_W
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Pins from the bus logic
  input wire logic sample_clock_i,
  input wire logic zero_all_n_i,
  input wire logic load_hold_i,
  input wire logic drive_allow_a_n_i,
  input wire logic drive_allow_b_n_i,
  input wire logic drive_allow_c_n_i,
  input wire logic [W-1:0] din_bits_i,
  // Gated outputs
  output logic [W-1:0] q_out_bits_o,
  output logic [W-1:0] q_out_oe_o
);
  import odr_pkg::*;

  // ------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------
  // Every pin, clock included, crosses through the same two stages so the
  // data seen at a detected edge is the data that stood at that edge.
  odr_pin_if #(.W(PIN_W)) pins ();

  assign pins.raw = {sample_clock_i, zero_all_n_i, load_hold_i, drive_allow_c_n_i,
                     drive_allow_b_n_i, drive_allow_a_n_i, din_bits_i};

  odr_pin_sync #(
    .W(PIN_W),
    .RESET_VAL(PIN_RESET)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pins(pins)
  );

  logic clk_s;
  logic clear_n_s;
  logic hold_s;
  logic [2:0] allow_n_s;
  logic [W-1:0] din_s;

  assign clk_s = pins.synced[POS_SAMPLE_CLK];
  assign clear_n_s = pins.synced[POS_ZERO_ALL];
  assign hold_s = pins.synced[POS_LOAD_HOLD];
  assign allow_n_s = pins.synced[POS_DRIVE_C:POS_DRIVE_A];
  assign din_s = pins.synced[POS_DIN_LO +: W];

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic clk_prev_r;
  logic clk_prev_nxt;
  logic [W-1:0] word_r;
  logic [W-1:0] word_nxt;
  logic rise;
  logic [W-1:0] load_bit;

  assign rise = clk_s & ~clk_prev_r;

  // One shared load strobe, one capture term per bit
  generate
    for (genvar i = 0; i < W; i++)
    begin : g_bit
      assign load_bit[i] = rise & clear_n_s & ~hold_s;
    end
  endgenerate

  always_comb
  begin
    clk_prev_nxt = clk_s;
    word_nxt = word_r;
    if (!clear_n_s)
    begin
      word_nxt = WORD_RESET;
    end
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (load_bit[i])
        begin
          word_nxt[i] = din_s[i];
        end
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      clk_prev_r <= SAMPLE_CLK_RESET;
      word_r <= WORD_RESET;
    end
    else
    begin
      clk_prev_r <= clk_prev_nxt;
      word_r <= word_nxt;
    end
  end

  // ------------------------------------------------------------
  // Output stage
  // ------------------------------------------------------------
  // Outputs follow the next word so they move on the same edge as storage.
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;
  logic [W-1:0] oe_r;
  logic [W-1:0] oe_nxt;

  always_comb
  begin
    q_nxt = INVERT_OUT ? ~word_nxt : word_nxt;
    oe_nxt = {W{allow_n_s == 3'b000}};
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      q_r <= INVERT_OUT ? ~WORD_RESET : WORD_RESET;
      oe_r <= OE_RESET;
    end
    else
    begin
      q_r <= q_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign q_out_bits_o = q_r;
  assign q_out_oe_o = oe_r;

endmodule : odr_register

`default_nettype wire

// ===== tb/odr_bus_drv.sv
// Bus-side model driving the register pins
`timescale 1ns/1ps
`default_nettype none
module odr_bus_drv (
  // Clock
  input wire logic clock_i,
  // Pins toward the register
  output logic sample_clock_o,
  output logic zero_all_n_o,
  output logic load_hold_o,
  output logic [2:0] en_n_o,
  output logic [7:0] din_o
);
  initial
  begin
    sample_clock_o = 1'b0;
    zero_all_n_o = 1'b1;
    load_hold_o = 1'b0;
    en_n_o = 3'h7;
    din_o = 8'h00;
  end
  // Four cycles covers sync latency and setup before a rise
  task automatic put(input logic [2:0] en, input logic clr, input logic hold,
    input logic [7:0] d);
    @(posedge clock_i);
    en_n_o <= en;
    zero_all_n_o <= clr;
    load_hold_o <= hold;
    din_o <= d;
    repeat (4) @(posedge clock_i);
  endtask : put
  task automatic pulse();
    @(posedge clock_i);
    sample_clock_o <= 1'b1;
    repeat (2) @(posedge clock_i);
    sample_clock_o <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask : pulse
endmodule : odr_bus_drv
`default_nettype wire

// ===== tb/odr_monitor.sv
// Checker for the gated eight-bit register
`timescale 1ns/1ps
`default_nettype none
module odr_monitor #(
  parameter bit INVERT_OUT = 1'b0,
  parameter int W = 8
) (
  // Clock and pins
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sample_clock_i,
  input wire logic zero_all_n_i,
  input wire logic load_hold_i,
  input wire logic drive_allow_a_n_i,
  input wire logic drive_allow_b_n_i,
  input wire logic drive_allow_c_n_i,
  input wire logic [W-1:0] din_bits_i,
  // Outputs
  input wire logic [W-1:0] q_out_bits_o,
  input wire logic [W-1:0] q_out_oe_o
);
  wire logic [W-1:0] mk = {W{INVERT_OUT}};
  wire logic off = drive_allow_a_n_i | drive_allow_b_n_i | drive_allow_c_n_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Three cycles: two sync flops plus the register
  AST_FLOAT: assert property (off |-> ##3 q_out_oe_o == 8'h00)
    else $error("driven while disabled");
  AST_DRIVE: assert property (!off |-> ##3 q_out_oe_o == 8'hFF)
    else $error("not driven while enabled");
  AST_OE_SAME: assert property (q_out_oe_o == 8'h00 || q_out_oe_o == 8'hFF)
    else $error("enables split");
  AST_CLEAR: assert property (!zero_all_n_i |-> ##3 q_out_bits_o == mk)
    else $error("clear missed");
  // Both compared samples must come from cycles with clear already low
  AST_CLEAR_STAYS: assert property (!zero_all_n_i [*2] |-> ##3 $stable(q_out_bits_o))
    else $error("load under clear");
  AST_HOLD: assert property (load_hold_i && zero_all_n_i |-> ##3 $stable(q_out_bits_o))
    else $error("changed in hold");
  AST_LOAD: assert property ($rose(sample_clock_i) && !load_hold_i && zero_all_n_i
    |-> ##3 q_out_bits_o == (mk ^ $past(din_bits_i, 3))) else $error("bad load");
  AST_EDGE_ONLY: assert property (!$rose(sample_clock_i) && zero_all_n_i
    |-> ##3 $stable(q_out_bits_o)) else $error("load off edge");
endmodule : odr_monitor
bind odr_register odr_monitor #(.INVERT_OUT(INVERT_OUT), .W(W)) u_odr_monitor (
  .clock_i(clock_i), .rst_i(rst_i), .sample_clock_i(sample_clock_i),
  .zero_all_n_i(zero_all_n_i), .load_hold_i(load_hold_i),
  .drive_allow_a_n_i(drive_allow_a_n_i), .drive_allow_b_n_i(drive_allow_b_n_i),
  .drive_allow_c_n_i(drive_allow_c_n_i), .din_bits_i(din_bits_i),
  .q_out_bits_o(q_out_bits_o), .q_out_oe_o(q_out_oe_o));
`default_nettype wire

// ===== tb/test_octal_tristate_dff_register.sv
// Testbench for the gated eight-bit register
`timescale 1ns/1ps
`default_nettype none
module test_octal_tristate_dff_register;
  localparam logic [7:0] MK = 8'hFF;
  logic clock_i, rst_i, sc, clr_n, hold;
  logic [2:0] en;
  logic [7:0] d, q, oe;
  int err_count = 0;
  int num_checks = 0;
  odr_bus_drv u_odr_bus_drv (.clock_i(clock_i), .sample_clock_o(sc), .zero_all_n_o(clr_n),
    .load_hold_o(hold), .en_n_o(en), .din_o(d));
  odr_register #(.INVERT_OUT(1'b1)) u_odr_register (.clock_i(clock_i), .rst_i(rst_i),
    .sample_clock_i(sc), .zero_all_n_i(clr_n), .load_hold_i(hold),
    .drive_allow_a_n_i(en[0]), .drive_allow_b_n_i(en[1]), .drive_allow_c_n_i(en[2]),
    .din_bits_i(d), .q_out_bits_o(q), .q_out_oe_o(oe));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    #1;
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic s_load();
    u_odr_bus_drv.put(3'h0, 1'b1, 1'b0, 8'hA5);
    u_odr_bus_drv.pulse();
    chk("q", q, 8'hA5 ^ MK);
    chk("oe", oe, 8'hFF);
    u_odr_bus_drv.put(3'h0, 1'b1, 1'b1, 8'h3C);
    u_odr_bus_drv.pulse();
    chk("q", q, 8'hA5 ^ MK);
  endtask : s_load
  task automatic s_float();
    for (int i = 0; i < 3; i++)
    begin
      u_odr_bus_drv.put(3'(3'h1 << i), 1'b1, 1'b0, 8'h0F);
      chk("oe", oe, 8'h00);
      // First pass still holds the word from s_load, later passes the 0F load
      chk("q", q, ((i == 0) ? 8'hA5 : 8'h0F) ^ MK);
      u_odr_bus_drv.pulse();
      chk("q", q, 8'h0F ^ MK);
    end
  endtask : s_float
  task automatic s_clear();
    u_odr_bus_drv.put(3'h0, 1'b0, 1'b0, 8'hC3);
    u_odr_bus_drv.pulse();
    chk("q", q, MK);
    u_odr_bus_drv.put(3'h0, 1'b1, 1'b0, 8'hC3);
    u_odr_bus_drv.pulse();
    chk("q", q, 8'hC3 ^ MK);
  endtask : s_clear
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  initial
  begin
    rst_i = 1'b1;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    s_load();
    s_float();
    s_clear();
    close_out();
  end
endmodule : test_octal_tristate_dff_register
`default_nettype wire
